// >>> core/eba_nvm_ctrl.sv
`timescale 1ns/1ns
module eba_nvm_ctrl #(
  parameter int unsigned ATOMIC_TICKS = eba_pkg::ATOMIC_TICKS,  // Atomic duration
  parameter int unsigned SPLIT_TICKS  = eba_pkg::SPLIT_TICKS    // Split duration
) (
  input  wire logic        pclk,       // Bus clock, 10 MHz
  input  wire logic        presetn,    // System reset, async, active low
  input  wire logic        por_n,      // Power-on reset, async, active low
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB access phase
  input  wire logic        pwrite,     // APB direction, high for write
  input  wire logic [11:0] paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready, low while the core stalls
  output logic             pslverr,    // APB error for unmapped address
  input  wire logic        osc_ref,    // Calibrated oscillator reference
  input  wire logic        gie,        // Global interrupt enable, same domain
  output logic             ready_irq   // Ready interrupt, level
);

  eba_nvm_if nvm ();                   // Link to the programming engine

  logic [6:0] addr_q, addr_d;          // nvm_address_reg
  logic [7:0] data_q, data_d;          // nvm_data_reg
  logic [1:0] mode_q, mode_d;          // programming_mode_bits
  logic       rie_q, rie_d;            // ready_interrupt_enable
  logic [2:0] arm_q, arm_d;            // Remaining arm window cycles
  logic [2:0] wait_q, wait_d;          // Access phase cycles already spent
  logic [2:0] need_q, need_d;          // Stall chosen at first access cycle
  logic       rd_go_q, rd_go_d;        // Read accepted for this access
  logic       pe_go_q, pe_go_d;        // Launch accepted for this access
  logic       rst_m_q, rst_s_q;        // System reset seen by the power-on domain
  logic [2:0] need_now;                // Stall for the access as it stands now
  logic       rd_now, pe_now;          // Decisions for the access as it stands now
  logic       access, first;           // Access phase, and its first cycle
  logic       done;                    // Transfer completes this edge
  logic       wr_ctrl;                 // Write to the control register
  logic       mapped;                  // Address hits a register
  logic       busy;                    // Operation running
  logic       armed;                   // Arm window open
  logic [1:0] wr_mode;                 // Mode field of the write data

  // Decode of one register offset
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  assign busy    = nvm.busy;
  assign armed   = (arm_q != 3'h0);
  assign access  = psel & penable;
  assign first   = access & (wait_q == 3'h0);
  assign wr_ctrl = access & pwrite & hit(paddr, eba_pkg::CTRL_REG_OFS);
  assign wr_mode = pwdata[eba_pkg::MODE_MSB_POS:eba_pkg::MODE_LSB_POS];
  assign mapped  = hit(paddr, eba_pkg::ADDR_REG_OFS) | hit(paddr, eba_pkg::DATA_REG_OFS)
                 | hit(paddr, eba_pkg::CTRL_REG_OFS) | hit(paddr, eba_pkg::STAT_REG_OFS);

  // Decide what the access does while the arm window is still open
  always_comb begin
    rd_now   = wr_ctrl & pwdata[eba_pkg::READ_STROBE_POS] & ~busy;
    // Launch needs the window, an idle engine and a defined mode
    pe_now   = wr_ctrl & pwdata[eba_pkg::PROG_BUSY_POS] & armed & ~busy
             & (mode_q != eba_pkg::MODE_RSVD);
    need_now = rd_now ? eba_pkg::READ_STALL
             : (pe_now ? eba_pkg::PROG_STALL : eba_pkg::NO_STALL);
  end

  // The decision is frozen at the first access cycle, because the arm window
  // can run out while the bus is being stalled
  always_comb begin
    need_d  = first ? need_now : need_q;
    rd_go_d = first ? rd_now : rd_go_q;
    pe_go_d = first ? pe_now : pe_go_q;
    pready  = access & (wait_q == (first ? need_now : need_q));
    done    = pready;
    wait_d  = (access & ~pready) ? wait_q + 3'h1 : 3'h0;
    pslverr = pready & ~mapped;
  end

  // Register next values
  always_comb begin
    addr_d = addr_q;
    data_d = data_q;
    rie_d  = rie_q;
    arm_d  = armed ? arm_q - 3'h1 : 3'h0;
    if (done && pwrite && mapped) begin
      // Address stays put while an operation runs
      if (hit(paddr, eba_pkg::ADDR_REG_OFS) && !busy) begin
        addr_d = pwdata[6:0];
      end
      if (hit(paddr, eba_pkg::DATA_REG_OFS)) begin
        data_d = pwdata[7:0];
      end
      if (hit(paddr, eba_pkg::CTRL_REG_OFS)) begin
        rie_d = pwdata[eba_pkg::RDY_IE_POS];
        if (pwdata[eba_pkg::ARM_POS]) begin
          arm_d = eba_pkg::ARM_CYCLES;
        end
      end
    end
    // Read result lands in the data register at the end of the strobe access
    if (done && rd_go_d) begin
      data_d = nvm.rdata;
    end
  end

  // Mode register next value, kept in the power-on domain
  always_comb begin
    mode_d = mode_q;
    if (!rst_s_q) begin
      // System reset clears the mode only when nothing is running
      mode_d = busy ? mode_q : eba_pkg::MODE_RST;
    end else if (done && wr_ctrl && !busy && !pe_go_d) begin
      mode_d = wr_mode;
    end
  end

  // Launch towards the engine
  always_comb begin
    nvm.start = done & pe_go_d;
    nvm.mode  = mode_q;
    nvm.addr  = addr_q;
    nvm.wdata = data_q;  // Unused by the engine in erase-only mode
  end

  // Registers cleared by the system reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q  <= eba_pkg::ADDR_RST;
      data_q  <= eba_pkg::DATA_RST;
      rie_q   <= 1'b0;
      arm_q   <= 3'h0;
      wait_q  <= 3'h0;
      need_q  <= eba_pkg::NO_STALL;
      rd_go_q <= 1'b0;
      pe_go_q <= 1'b0;
    end else begin
      addr_q  <= addr_d;
      data_q  <= data_d;
      rie_q   <= rie_d;
      arm_q   <= arm_d;
      wait_q  <= wait_d;
      need_q  <= need_d;
      rd_go_q <= rd_go_d;
      pe_go_q <= pe_go_d;
    end
  end

  // System reset brought into the power-on domain through two flops
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= presetn;
      rst_s_q <= rst_m_q;
    end
  end

  // Mode bits survive a system reset taken while busy
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      mode_q <= eba_pkg::MODE_RST;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Register read mux; reserved bits read as zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (access && !pwrite) begin
      if (hit(paddr, eba_pkg::ADDR_REG_OFS)) begin
        prdata[6:0] = addr_q;
      end else if (hit(paddr, eba_pkg::DATA_REG_OFS)) begin
        prdata[7:0] = data_q;
      end else if (hit(paddr, eba_pkg::CTRL_REG_OFS)) begin
        prdata[eba_pkg::PROG_BUSY_POS] = busy;
        prdata[eba_pkg::ARM_POS]       = armed;
        prdata[eba_pkg::RDY_IE_POS]    = rie_q;
        prdata[eba_pkg::MODE_MSB_POS:eba_pkg::MODE_LSB_POS] = mode_q;
      end else if (hit(paddr, eba_pkg::STAT_REG_OFS)) begin
        prdata[eba_pkg::STAT_IRQ_POS]  = ready_irq;
        prdata[eba_pkg::STAT_BUSY_POS] = busy;
      end
    end
  end

  // Level interrupt, held for as long as the engine is idle and both rie_q and gie are set
  assign ready_irq = rie_q & gie & ~busy;

  // Programming engine and byte array
  eba_nvm_core #(
    .ATOMIC_TICKS (ATOMIC_TICKS),
    .SPLIT_TICKS  (SPLIT_TICKS)
  ) u_core (
    .pclk    (pclk),
    .por_n   (por_n),
    .osc_ref (osc_ref),
    .nvm     (nvm)
  );

endmodule // eba_nvm_ctrl

// >>> inc/eba_pkg.sv
// Shared constants for the byte-wide non-volatile data memory access block
package eba_pkg;

  // Register byte offsets on the APB (one aligned word each)
  localparam logic [11:0] ADDR_REG_OFS   = 12'h000;   // nvm_address_reg
  localparam logic [11:0] DATA_REG_OFS   = 12'h004;   // nvm_data_reg
  localparam logic [11:0] CTRL_REG_OFS   = 12'h008;   // nvm_control_reg
  localparam logic [11:0] STAT_REG_OFS   = 12'h00C;   // Status of the block

  // Control register bit positions
  localparam int unsigned READ_STROBE_POS = 0;        // read_strobe_bit
  localparam int unsigned PROG_BUSY_POS   = 1;        // program_enable_busy_bit
  localparam int unsigned ARM_POS         = 2;        // master_program_arm_bit
  localparam int unsigned RDY_IE_POS      = 3;        // ready_interrupt_enable
  localparam int unsigned MODE_LSB_POS    = 4;        // programming_mode_bits[0]
  localparam int unsigned MODE_MSB_POS    = 5;        // programming_mode_bits[1]

  // Status register bit positions
  localparam int unsigned STAT_IRQ_POS    = 0;        // Ready interrupt line
  localparam int unsigned STAT_BUSY_POS   = 1;        // Programming in progress

  // Memory geometry
  localparam int unsigned NVM_ADDR_W = 7;             // 128 bytes
  localparam int unsigned NVM_DATA_W = 8;             // Byte wide

  // Values after reset, and the content of an erased cell
  localparam logic [6:0] ADDR_RST  = 7'h00;           // Address register
  localparam logic [7:0] DATA_RST  = 8'h00;           // Data register
  localparam logic [1:0] MODE_RST  = 2'h0;            // Mode bits
  localparam logic [7:0] ERASED_BYTE = 8'hFF;         // Content of an erased cell

  // Programming mode encodings
  localparam logic [1:0] MODE_ATOMIC = 2'h0;          // Erase then write
  localparam logic [1:0] MODE_ERASE  = 2'h1;          // Erase only
  localparam logic [1:0] MODE_WRITE  = 2'h2;          // Write only
  localparam logic [1:0] MODE_RSVD   = 2'h3;          // Reserved, no operation

  // Cycle counts on pclk
  localparam logic [2:0] ARM_CYCLES  = 3'h4;          // Arm window length
  localparam logic [2:0] READ_STALL  = 3'h4;          // Bus stall after a read strobe
  localparam logic [2:0] PROG_STALL  = 3'h2;          // Bus stall after a launch
  localparam logic [2:0] NO_STALL    = 3'h0;          // Plain access

  // Programming times, timed from the calibrated oscillator reference
  localparam int unsigned ATOMIC_TIME_US = 3400;      // 3.4 ms
  localparam int unsigned SPLIT_TIME_US  = 1800;      // 1.8 ms
  localparam int unsigned OSC_REF_KHZ    = 1000;      // Reference rate seen at osc_ref
  localparam int unsigned ATOMIC_TICKS   = ATOMIC_TIME_US * OSC_REF_KHZ / 1000;
  localparam int unsigned SPLIT_TICKS    = SPLIT_TIME_US * OSC_REF_KHZ / 1000;
  localparam int unsigned TICK_CNT_W     = 16;        // Width of the time counter

  // Programming engine states
  typedef enum logic {
    ENG_IDLE,
    ENG_RUN
  } eba_eng_e;

endpackage

// >>> inc/eba_nvm_if.sv
`timescale 1ns/1ns
// Link between the register side and the programming engine
interface eba_nvm_if;
  logic       start;        // One-cycle launch pulse
  logic [1:0] mode;         // Operation selected at launch
  logic [6:0] addr;         // Byte address for launch and read
  logic [7:0] wdata;        // Byte to store
  logic [7:0] rdata;        // Byte stored at addr
  logic       busy;         // Operation running

  modport ctrl (output start, output mode, output addr, output wdata,
                input rdata, input busy);
  modport core (input start, input mode, input addr, input wdata,
                output rdata, output busy);
endinterface // eba_nvm_if

// >>> core/eba_nvm_core.sv
`timescale 1ns/1ns
// Programming engine and byte array; the engine is reset only by power-on so that a
// running operation survives a system reset.
module eba_nvm_core #(
  parameter int unsigned ATOMIC_TICKS = eba_pkg::ATOMIC_TICKS,  // Atomic duration
  parameter int unsigned SPLIT_TICKS  = eba_pkg::SPLIT_TICKS    // Split duration
) (
  input  wire logic pclk,       // Bus clock
  input  wire logic por_n,      // Power-on reset, active low
  input  wire logic osc_ref,    // Calibrated oscillator reference, asynchronous
  eba_nvm_if.core   nvm         // Link to the register side
);

  logic                 osc_m_q, osc_s_q, osc_p_q;        // Synchroniser and edge flop
  logic                 tick;                              // One reference edge
  eba_pkg::eba_eng_e    state_q, state_d;                  // Engine state
  logic [15:0]          cnt_q, cnt_d;                      // Elapsed reference edges
  logic [15:0]          lim_q, lim_d;                      // Edges for this operation
  logic [1:0]           opm_q, opm_d;                      // Latched mode
  logic [6:0]           opa_q, opa_d;                      // Latched address
  logic [7:0]           opd_q, opd_d;                      // Latched data
  logic [7:0]           mem_q [128];                       // Byte array
  logic [7:0]           mem_d [128];                       // Next array content

  // Reference crosses in through two flops before the edge detector
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      osc_m_q <= 1'b0;
      osc_s_q <= 1'b0;
      osc_p_q <= 1'b0;
    end else begin
      osc_m_q <= osc_ref;
      osc_s_q <= osc_m_q;
      osc_p_q <= osc_s_q;
    end
  end

  assign tick = osc_s_q & ~osc_p_q;  // Timing uses the oscillator, not pclk

  // Next state of the engine and the array
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    lim_d   = lim_q;
    opm_d   = opm_q;
    opa_d   = opa_q;
    opd_d   = opd_q;
    mem_d   = mem_q;
    case (state_q)
      eba_pkg::ENG_IDLE: begin
        // Reserved mode is screened by the register side
        if (nvm.start) begin
          state_d = eba_pkg::ENG_RUN;
          cnt_d   = 16'h0000;
          opm_d   = nvm.mode;
          opa_d   = nvm.addr;
          opd_d   = nvm.wdata;
          lim_d   = (nvm.mode == eba_pkg::MODE_ATOMIC) ? 16'(ATOMIC_TICKS)
                                                        : 16'(SPLIT_TICKS);
        end
      end
      eba_pkg::ENG_RUN: begin
        if (tick) begin
          cnt_d = cnt_q + 16'h0001;
        end
        // Cell content changes only when the full time has elapsed
        if (tick && (cnt_q + 16'h0001 >= lim_q)) begin
          state_d = eba_pkg::ENG_IDLE;
          case (opm_q)
            eba_pkg::MODE_ATOMIC: mem_d[opa_q] = opd_q;
            eba_pkg::MODE_ERASE:  mem_d[opa_q] = eba_pkg::ERASED_BYTE;
            // Unerased target gives a mixed value, which software treats as lost
            eba_pkg::MODE_WRITE:  mem_d[opa_q] = mem_q[opa_q] & opd_q;
            default:              mem_d[opa_q] = mem_q[opa_q];
          endcase
        end
      end
      default: state_d = eba_pkg::ENG_IDLE;
    endcase
  end

  // Only power-on clears the engine, so a system reset lets it finish
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      state_q <= eba_pkg::ENG_IDLE;
      cnt_q   <= 16'h0000;
      lim_q   <= 16'h0000;
      opm_q   <= eba_pkg::MODE_RST;
      opa_q   <= eba_pkg::ADDR_RST;
      opd_q   <= eba_pkg::DATA_RST;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      lim_q   <= lim_d;
      opm_q   <= opm_d;
      opa_q   <= opa_d;
      opd_q   <= opd_d;
    end
  end

  // Array keeps its content through every reset, as a non-volatile store would
  always_ff @(posedge pclk) begin
    mem_q <= mem_d;
  end

  assign nvm.busy  = (state_q == eba_pkg::ENG_RUN);
  assign nvm.rdata = mem_q[nvm.addr];

endmodule // eba_nvm_core

// >>> verif/eba_nvm_ctrl_monitor.sv
`timescale 1ns/1ns
// Watches the bus side of the access block from its ports alone
module eba_nvm_ctrl_monitor #(
  parameter int unsigned ATOMIC_TICKS = eba_pkg::ATOMIC_TICKS,  // Atomic duration
  parameter int unsigned SPLIT_TICKS  = eba_pkg::SPLIT_TICKS    // Split duration
) (
  input wire logic        pclk,       // Bus clock
  input wire logic        presetn,    // System reset, active low
  input wire logic        por_n,      // Power-on reset, active low
  input wire logic        psel,       // APB select
  input wire logic        penable,    // APB access phase
  input wire logic        pwrite,     // APB direction
  input wire logic [11:0] paddr,      // APB address
  input wire logic [31:0] pwdata,     // APB write data
  input wire logic [31:0] prdata,     // APB read data
  input wire logic        pready,     // APB ready
  input wire logic        pslverr,    // APB error
  input wire logic        osc_ref,    // Oscillator reference
  input wire logic        gie,        // Global interrupt enable
  input wire logic        ready_irq   // Ready interrupt
);
  logic       setup_q;    // Previous cycle was a setup cycle
  logic       setup_d;    // Next value of setup_q
  logic [2:0] arm_age_q;  // Cycles since arm was written, saturates at 7
  logic [2:0] arm_age_d;  // Next value of arm_age_q
  logic       acc_first;  // First cycle of an access phase
  logic       done;       // Access completes at this edge
  logic       ctl_wr;     // First access cycle of a control write
  logic       ctl_rd;     // Completing control read
  logic       stat_rd;    // Completing status read

  assign acc_first = psel && penable && setup_q;
  assign done      = psel && penable && pready;
  assign ctl_wr    = acc_first && pwrite && paddr == eba_pkg::CTRL_REG_OFS;
  assign ctl_rd    = done && !pwrite && paddr == eba_pkg::CTRL_REG_OFS;
  assign stat_rd   = done && !pwrite && paddr == eba_pkg::STAT_REG_OFS;

  // Next values of the helper state
  always_comb begin
    setup_d   = psel && !penable;
    arm_age_d = (arm_age_q == 3'h7) ? arm_age_q : arm_age_q + 3'h1;
    if (done && pwrite && paddr == eba_pkg::CTRL_REG_OFS && pwdata[2]) begin
      arm_age_d = 3'h0;  // Window restarts on every arm write
    end
  end

  // Reset saturates the age so a stale window is never assumed open
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      setup_q   <= 1'b0;
      arm_age_q <= 3'h7;
    end else begin
      setup_q   <= setup_d;
      arm_age_q <= arm_age_d;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wait4;
    (!pready) [*4] ##1 pready;
  endsequence
  sequence s_wait2;
    (!pready) [*2] ##1 pready;
  endsequence

  chk_read_stall_four: assert property (ctl_wr && pwdata[0] && !pready |-> s_wait4)
    else $error("read strobe stall is not four cycles");
  chk_launch_stall_two: assert property (
    ctl_wr && pwdata[1] && !pwdata[0] && !pready |-> s_wait2)
    else $error("launch stall is not two cycles");
  chk_access_bounded: assert property (acc_first |-> ##[0:4] pready)
    else $error("access not answered within four waits");
  chk_irq_needs_gie: assert property (!gie |-> !ready_irq)
    else $error("ready interrupt without global enable");
  chk_stat_irq_busy: assert property (
    stat_rd |-> prdata[0] == ready_irq && !(prdata[0] && prdata[1]))
    else $error("ready interrupt disagrees with busy");
  chk_arm_open: assert property (ctl_rd && arm_age_q <= 3'h2 |-> prdata[2])
    else $error("arm bit closed too early");
  chk_arm_expire: assert property (ctl_rd && arm_age_q >= 3'h5 |-> !prdata[2])
    else $error("arm bit not cleared after four cycles");
  chk_strobe_reads_zero: assert property (ctl_rd |-> !prdata[0] && prdata[31:6] == 26'h0)
    else $error("control read shows strobe or unused bits");
endmodule // eba_nvm_ctrl_monitor

bind eba_nvm_ctrl eba_nvm_ctrl_monitor #(
  .ATOMIC_TICKS(ATOMIC_TICKS),
  .SPLIT_TICKS (SPLIT_TICKS)
) u_mon (
  .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .osc_ref(osc_ref), .gie(gie), .ready_irq(ready_irq)
);

// >>> verif/tb.sv
`timescale 1ns/1ns
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
  localparam int unsigned ATK   = 20;  // Shortened atomic duration in osc edges
  localparam int unsigned SPT   = 10;  // Shortened split duration in osc edges
  localparam logic [11:0] A_ADR = eba_pkg::ADDR_REG_OFS;  // Address register
  localparam logic [11:0] A_DAT = eba_pkg::DATA_REG_OFS;  // Data register
  localparam logic [11:0] A_CTL = eba_pkg::CTRL_REG_OFS;  // Control register
  localparam logic [11:0] A_STA = eba_pkg::STAT_REG_OFS;  // Status register
  logic        pclk, presetn, por_n, psel, penable, pwrite, osc_ref, gie;
  logic [11:0] paddr;       // Bus address
  logic [31:0] pwdata;      // Bus write data
  logic [31:0] prdata;      // Bus read data
  logic        pready, pslverr, ready_irq;
  logic [31:0] v;           // Word of the last access
  logic        err;         // Error flag of the last access
  int          mismatches = 0;
  int          tests_run  = 0;
  int          osc_cnt    = 0;  // Reference edges seen so far

  eba_nvm_ctrl #(.ATOMIC_TICKS(ATK), .SPLIT_TICKS(SPT)) dut (
    .pclk(pclk), .presetn(presetn), .por_n(por_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_ref(osc_ref), .gie(gie), .ready_irq(ready_irq)
  );

  // Bus clock, 100 ns period
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Reference at an odd phase, three bus clock periods long, so edges keep a fixed offset to the bus clock
  initial begin
    osc_ref = 1'b0;
    #37;
    forever #150 osc_ref = ~osc_ref;
  end

  always @(posedge osc_ref) osc_cnt++;

  task automatic tally_and_finish;
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // One APB transfer; ready, read data and error are all taken at the rising edge
  // that completes the access, and only then is the request released
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int   n;
    logic ok;
    psel   <= 1'b1;
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    ok = 1'b0;
    for (n = 0; n < 20 && !ok; n++) begin
      @(posedge pclk);
      ok  = (pready === 1'b1);
      v   = prdata;
      err = pslverr;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!ok) begin
      mismatches++;
      tally_and_finish();
    end
    @(posedge pclk);  // Idle cycle keeps every bus signal to one assignment per step
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(a, 1'b0, 32'h0000_0000);
  endtask

  // Strobed read of one byte
  task automatic rbyte(input logic [6:0] a, input logic [7:0] e);
    wr(A_ADR, {25'h0, a});
    wr(A_CTL, 32'h0000_0001);
    rd(A_DAT);
    `CHK(v[7:0], e)
  endtask

  // Armed launch, optional disturbance while busy, then wait and time it
  task automatic prog(input logic [6:0] a, input logic [7:0] d, input logic [1:0] m,
                      input int t, input logic poke);
    int s;
    int n;
    wr(A_ADR, {25'h0, a});
    wr(A_DAT, {24'h0, d});
    wr(A_CTL, {26'h0, m, 4'hC});
    wr(A_CTL, {26'h0, m, 4'hA});
    s = osc_cnt;
    rd(A_STA);
    `CHK(v[1], m !== eba_pkg::MODE_RSVD)
    `CHK(ready_irq, m === eba_pkg::MODE_RSVD)
    if (poke) begin
      wr(A_ADR, 32'h0000_007F);
      wr(A_CTL, 32'h0000_0019);
      rd(A_ADR);
      `CHK(v[6:0], a)
      rd(A_DAT);
      `CHK(v[7:0], d)
      rd(A_CTL);
      `CHK(v[5:0], {m, 4'hA})
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(A_CTL);
      `CHK(v[5:0], {m, 4'h2})
    end
    n = 0;
    while (v[1] === 1'b1 && n < 400) begin
      rd(A_STA);
      n++;
    end
    `CHK(v[1], 1'b0)
    if (m !== eba_pkg::MODE_RSVD) begin
      `CHK((osc_cnt - s) >= t - 1 && (osc_cnt - s) <= t + 3, 1'b1)
    end
  endtask

  initial begin
    logic [11:0] offs [4];
    offs    = '{A_ADR, A_DAT, A_CTL, A_STA};
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
    gie     = 1'b0;
    por_n   = 1'b0;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    por_n   <= 1'b1;
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) begin
      rd(offs[i]);
      `CHK(v, 32'h0000_0000)
    end
    rd(12'h010);
    `CHK({err, v}, {1'b1, 32'h0000_0000})
    wr(A_CTL, 32'h0000_0008);
    `CHK(ready_irq, 1'b0)
    gie <= 1'b1;
    @(posedge pclk);
    `CHK(ready_irq, 1'b1)
    prog(7'h05, 8'hA5, eba_pkg::MODE_ATOMIC, ATK, 1'b1);
    rbyte(7'h05, 8'hA5);
    prog(7'h05, 8'h11, eba_pkg::MODE_ERASE, SPT, 1'b0);
    rbyte(7'h05, eba_pkg::ERASED_BYTE);
    prog(7'h05, 8'h3C, eba_pkg::MODE_WRITE, SPT, 1'b0);
    rbyte(7'h05, 8'h3C);
    prog(7'h05, 8'h77, eba_pkg::MODE_RSVD, 0, 1'b0);
    rbyte(7'h05, 8'h3C);
    wr(A_CTL, 32'h0000_0004);
    rd(A_CTL);
    `CHK(v[2], 1'b1)
    repeat (6) @(posedge pclk);
    rd(A_CTL);
    `CHK(v[2], 1'b0)
    wr(A_CTL, 32'h0000_0002);
    rd(A_STA);
    `CHK(v[1], 1'b0)
    // System reset while idle must bring the mode bits back to their reset value
    wr(A_CTL, 32'h0000_0010);
    rd(A_CTL);
    `CHK(v[5:4], eba_pkg::MODE_ERASE)
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(A_CTL);
    `CHK(v[5:4], eba_pkg::MODE_RST)
    tally_and_finish();
  end
endmodule // tb
